//--- inc/adcmux_pkg.sv
// Constants and types shared by the converter input-mux and coding logic.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package adcmux_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] ADCMUX_IDX_STATUS     = 6'h00;
  localparam logic [5:0] ADCMUX_IDX_MODE       = 6'h01;
  localparam logic [5:0] ADCMUX_IDX_DATA       = 6'h04;
  localparam logic [5:0] ADCMUX_IDX_CH_BASE    = 6'h10;
  localparam logic [5:0] ADCMUX_IDX_SETUP_BASE = 6'h20;

  // Sizes
  localparam int ADCMUX_NUM_CH    = 16;
  localparam int ADCMUX_NUM_SETUP = 8;
  localparam int ADCMUX_RES_W     = 24;
  localparam int ADCMUX_PIN_N     = 17;

  // Pin codes used in the channel input field
  localparam logic [4:0] ADCMUX_HV_LAST   = 5'h0A;
  localparam logic [4:0] ADCMUX_LL_FIRST  = 5'h0B;
  localparam logic [4:0] ADCMUX_LL_COMMON = 5'h0F;
  localparam logic [4:0] ADCMUX_VCOMMON   = 5'h10;

  // Mode register fields
  localparam int         ADCMUX_MODE_REFEN_BIT = 15;
  localparam int         ADCMUX_MODE_SCYC_BIT  = 13;
  localparam int         ADCMUX_MODE_FIELD_LSB = 4;
  localparam logic [2:0] ADCMUX_MODE_CONT      = 3'h0;

  // Channel register fields
  localparam int ADCMUX_CH_EN_BIT    = 15;
  localparam int ADCMUX_CH_SETUP_LSB = 12;
  localparam int ADCMUX_CH_POS_LSB   = 5;
  localparam int ADCMUX_CH_NEG_LSB   = 0;

  // Setup register fields
  localparam int ADCMUX_SU_BIPOLAR_BIT = 12;
  localparam int ADCMUX_SU_INBUF_LSB   = 8;
  localparam int ADCMUX_SU_REFSEL_LSB  = 4;

  // Reference select codes
  localparam logic [1:0] ADCMUX_REF_EXT    = 2'h0;
  localparam logic [1:0] ADCMUX_REF_INT    = 2'h2;
  localparam logic [1:0] ADCMUX_REF_SUPPLY = 2'h3;

  // Reset values
  localparam logic [15:0] ADCMUX_MODE_RST  = 16'h2000;
  localparam logic [15:0] ADCMUX_CH0_RST   = 16'h8001;
  localparam logic [15:0] ADCMUX_CHN_RST   = 16'h0001;
  localparam logic [15:0] ADCMUX_SETUP_RST = 16'h1000;

  // Bus responses
  localparam logic [1:0] ADCMUX_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ADCMUX_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {ADCMUX_IDLE, ADCMUX_CONVERT} adcmux_state_t;

endpackage

//--- verilog/adcmux_pair_decode.sv
// Decodes one channel input field into legal one-hot mux selections.
// Pure combinational; the caller registers the outputs.
`timescale 1ns/1ps
module adcmux_pair_decode
  import adcmux_pkg::*;
(
  input  wire logic [9:0]              inputField,
  input  wire logic [1:0]              inBufEn,
  output logic      [ADCMUX_PIN_N-1:0] posOneHot,
  output logic      [ADCMUX_PIN_N-1:0] negOneHot,
  output logic                         legal,
  output logic                         hvPath,
  output logic                         bypass
);

  wire logic [4:0] posPin = inputField[ADCMUX_CH_POS_LSB +: 5];
  wire logic [4:0] negPin = inputField[ADCMUX_CH_NEG_LSB +: 5];

  // High-voltage legality: fixed even/odd pairs or any input against common
  wire logic posHv    = posPin <= ADCMUX_HV_LAST;
  wire logic hvDiff   = posHv && !posPin[0] && (negPin == posPin + 5'h01)
                        && (posPin != ADCMUX_HV_LAST);                   // see R6
  wire logic hvSingle = posHv && (negPin == ADCMUX_VCOMMON);             // see R6, R7
  // Low-level crosspoint: any two distinct low-level pins, either role
  wire logic posLl    = (posPin >= ADCMUX_LL_FIRST) && (posPin <= ADCMUX_LL_COMMON);
  wire logic negLl    = (negPin >= ADCMUX_LL_FIRST) && (negPin <= ADCMUX_LL_COMMON);
  wire logic llPair   = posLl && negLl && (posPin != negPin);            // see R9, R10, R11

  assign legal  = hvDiff || hvSingle || llPair;
  assign hvPath = hvDiff || hvSingle;
  // Buffers off means mux drives the sampling capacitor directly
  assign bypass = (inBufEn == 2'h0);                                     // see R5

  // One-hot pin selects; an illegal pair leaves the mux open
  genvar p;
  generate
    for (p = 0; p < ADCMUX_PIN_N; p++)
    begin : gSel
      assign posOneHot[p] = legal && (posPin == 5'(p));
      assign negOneHot[p] = legal && (negPin == 5'(p));
    end
  endgenerate

endmodule

//--- verilog/adcmux_ctrl.sv
// Channel sequencer, input-pair mux control, reference control and output
// coding for a 24-bit converter, with an AXI4-Lite register slave.
// Assumes the modulator/filter runs on clk and returns one signed result
// per started conversion as a one-cycle convDone pulse.
//
// Summary of operation
// R1 - Sixteen channels, each picking its own input pair through the mux.
// R2 - Enabled channels are converted in ascending order, lowest to highest.
// R3 - Channels whose enable bit is clear are skipped.
// R4 - After the highest enabled channel, continuous mode wraps to the lowest.
// R5 - Input buffers can be bypassed; mux then feeds the sampler directly.
// R6 - High-voltage differential pairs: 0/1, 2/3, 4/5, 6/7, 8/9, 10/common.
// R7 - Up to eleven high-voltage inputs pair with the common input singly.
// R8 - Software should enable input buffers for high-voltage channels.
// R9 - Any low-level input may be either member of a pair.
// R10 - Low-level differential pairs are 11/12 and 13/14.
// R11 - Up to four low-level inputs pair with input 15 as common.
// R12 - Unipolar coding is straight binary: zero, midscale top bit, full ones.
// R13 - Bipolar coding is offset binary: zero input gives top bit only.
// R14 - High-voltage results carry the one-tenth divider attenuation.
// R15 - Low-level results have no attenuation; result width is 24 bits.
// R16 - Setup bits 5:4 pick external, supply or internal reference.
// R17 - External reference is selected after reset.
// R18 - Internal reference off after reset; drives its pin once enabled.
// R19 - Internal reference enable is mode register bit 15.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module adcmux_ctrl
  import adcmux_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic [ADDR_W-1:0]        awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [ADDR_W-1:0]        araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  input  wire logic                     convDone,
  input  wire logic [ADCMUX_RES_W-1:0]  convRaw,
  output logic                          convStart,
  output logic [ADCMUX_PIN_N-1:0]       muxPosSel,
  output logic [ADCMUX_PIN_N-1:0]       muxNegSel,
  output logic                          bufferBypass,
  output logic                          attenuatedPath,
  output logic [1:0]                    referenceSelect,
  output logic                          referenceOutputEnable
);

  logic [15:0]             modeReg;
  logic [15:0]             chReg [ADCMUX_NUM_CH];
  logic [15:0]             setupReg [ADCMUX_NUM_SETUP];
  logic [ADCMUX_RES_W-1:0] resultReg;
  logic [3:0]              resultCh;
  logic                    dataReady;
  logic [3:0]              curCh;
  adcmux_state_t           state;

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] mergeHalf(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction

  // Next enabled channel above cur, wrapping; used for advance and restart
  function automatic logic [4:0] nextEnabled(input logic [ADCMUX_NUM_CH-1:0] mask,
                                             input logic [3:0]               cur);
    logic [4:0] res;
    logic [3:0] idx;
    res = 5'h00;
    for (int i = ADCMUX_NUM_CH; i >= 1; i--)
    begin
      idx = cur + 4'(i);
      if (mask[idx])
        res = {1'b1, idx};
    end
    return res;
  endfunction

  // Enable mask gathered from all channel registers
  logic [ADCMUX_NUM_CH-1:0] enMask;
  genvar c;
  generate
    for (c = 0; c < ADCMUX_NUM_CH; c++)
    begin : gEn
      assign enMask[c] = chReg[c][ADCMUX_CH_EN_BIT];                    // see R1, R3
    end
  endgenerate

  // Current channel and its setup
  wire logic [15:0] curChReg = chReg[curCh];
  wire logic [2:0]  curSetup = curChReg[ADCMUX_CH_SETUP_LSB +: 3];
  wire logic [15:0] curSuReg = setupReg[curSetup];
  wire logic        bipolar  = curSuReg[ADCMUX_SU_BIPOLAR_BIT];
  wire logic [2:0]  modeSel  = modeReg[ADCMUX_MODE_FIELD_LSB +: 3];
  wire logic        contMode = (modeSel == ADCMUX_MODE_CONT);

  // Pair decode for the channel under conversion
  logic [ADCMUX_PIN_N-1:0] decPos;
  logic [ADCMUX_PIN_N-1:0] decNeg;
  logic                    decLegal;
  logic                    decHv;
  logic                    decBypass;

  adcmux_pair_decode uDecode (
    .inputField (curChReg[9:0]),
    .inBufEn    (curSuReg[ADCMUX_SU_INBUF_LSB +: 2]),
    .posOneHot  (decPos),
    .negOneHot  (decNeg),
    .legal      (decLegal),
    .hvPath     (decHv),
    .bypass     (decBypass)
  );

  // Output coding; raw is a signed fraction of the reference
  wire logic [ADCMUX_RES_W-1:0] bipolarCode  = {~convRaw[ADCMUX_RES_W-1],
                                                convRaw[ADCMUX_RES_W-2:0]};      // see R13
  wire logic [ADCMUX_RES_W-1:0] unipolarCode = convRaw[ADCMUX_RES_W-1]
                                               ? '0
                                               : {convRaw[ADCMUX_RES_W-2:0], 1'b0}; // see R12
  // Divider attenuation is analog; the code scaling itself is identical
  wire logic [ADCMUX_RES_W-1:0] codedResult  = bipolar ? bipolarCode : unipolarCode; // see R14, R15

  // Sequencer decisions
  wire logic [4:0] advance  = nextEnabled(enMask, curCh);               // see R2, R3, R4
  wire logic [4:0] firstCh  = nextEnabled(enMask, 4'hF);                // see R2
  wire logic       convEnd  = (state == ADCMUX_CONVERT) && convDone;

  // Bus decode
  wire logic [5:0] wrIdx    = awaddr[7:2];
  wire logic [5:0] rdIdx    = araddr[7:2];
  wire logic       wrFire   = awready;
  wire logic       rdFire   = arready;
  wire logic       wrMode   = wrIdx == ADCMUX_IDX_MODE;
  wire logic       wrCh     = wrIdx[5:4] == ADCMUX_IDX_CH_BASE[5:4];
  wire logic       wrSetup  = wrIdx[5:3] == ADCMUX_IDX_SETUP_BASE[5:3];
  wire logic       wrHit    = wrMode || wrCh || wrSetup;
  wire logic       rdIsCh   = rdIdx[5:4] == ADCMUX_IDX_CH_BASE[5:4];
  wire logic       rdIsSu   = rdIdx[5:3] == ADCMUX_IDX_SETUP_BASE[5:3];
  wire logic       rdIsData = rdIdx == ADCMUX_IDX_DATA;
  wire logic       rdIsStat = rdIdx == ADCMUX_IDX_STATUS;
  wire logic       rdIsMode = rdIdx == ADCMUX_IDX_MODE;
  wire logic       rdHit    = rdIsCh || rdIsSu || rdIsData || rdIsStat || rdIsMode;
  wire logic [31:0] statusWord = {24'h000000, curCh, 1'b0,
                                  state == ADCMUX_CONVERT, !decLegal, dataReady};
  wire logic [31:0] rdWord   = rdIsCh   ? {16'h0000, chReg[rdIdx[3:0]]}
                             : rdIsSu   ? {16'h0000, setupReg[rdIdx[2:0]]}
                             : rdIsMode ? {16'h0000, modeReg}
                             : rdIsData ? {8'h00, resultReg}
                             : rdIsStat ? statusWord
                             : 32'h00000000;

  // Write channel: address and data taken together, one at a time
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= ADCMUX_RESP_OKAY;
    end
    else
    begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !awready && !bvalid;
      if (wrFire)
      begin
        bvalid <= 1'b1;
        bresp  <= wrHit ? ADCMUX_RESP_OKAY : ADCMUX_RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // Read channel: data captured in the accept cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= ADCMUX_RESP_OKAY;
    end
    else
    begin
      arready <= arvalid && !arready && !rvalid;
      if (rdFire)
      begin
        rvalid <= 1'b1;
        rdata  <= rdWord;
        rresp  <= rdHit ? ADCMUX_RESP_OKAY : ADCMUX_RESP_SLVERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      modeReg <= ADCMUX_MODE_RST;                                       // see R18, R19
      for (int i = 0; i < ADCMUX_NUM_CH; i++)
        chReg[i] <= (i == 0) ? ADCMUX_CH0_RST : ADCMUX_CHN_RST;
      for (int i = 0; i < ADCMUX_NUM_SETUP; i++)
        setupReg[i] <= ADCMUX_SETUP_RST;                                // see R17
    end
    else if (wrFire)
    begin
      if (wrMode)
        modeReg <= mergeHalf(modeReg, wdata, wstrb);
      if (wrCh)
        chReg[wrIdx[3:0]] <= mergeHalf(chReg[wrIdx[3:0]], wdata, wstrb);
      if (wrSetup)
        setupReg[wrIdx[2:0]] <= mergeHalf(setupReg[wrIdx[2:0]], wdata, wstrb); // see R16
    end
  end

  // Sequencer: one conversion per enabled channel, ascending, wrapping
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state     <= ADCMUX_IDLE;
      curCh     <= 4'h0;
      convStart <= 1'b0;
    end
    else
    begin
      convStart <= 1'b0;
      case (state)
        ADCMUX_IDLE:
        begin
          if (contMode && firstCh[4])
          begin
            curCh     <= firstCh[3:0];                                  // see R2
            convStart <= 1'b1;
            state     <= ADCMUX_CONVERT;
          end
        end
        ADCMUX_CONVERT:
        begin
          if (convDone)
          begin
            if (contMode && advance[4])
            begin
              curCh     <= advance[3:0];                                // see R3, R4
              convStart <= 1'b1;
            end
            else
              state <= ADCMUX_IDLE;
          end
        end
        default:
          state <= ADCMUX_IDLE;
      endcase
    end
  end

  // Result capture; a new result beats a clearing read in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      resultReg <= '0;
      resultCh  <= 4'h0;
      dataReady <= 1'b0;
    end
    else if (convEnd)
    begin
      resultReg <= codedResult;                                         // see R12, R13
      resultCh  <= curCh;
      dataReady <= 1'b1;
    end
    else if (rdFire && rdIsData)
      dataReady <= 1'b0;
  end

  // Analog control outputs, registered from the current channel, its setup and the mode register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      muxPosSel             <= '0;
      muxNegSel             <= '0;
      bufferBypass          <= 1'b0;
      attenuatedPath        <= 1'b0;
      referenceSelect       <= ADCMUX_REF_EXT;                          // see R17
      referenceOutputEnable <= 1'b0;                                    // see R18
    end
    else
    begin
      muxPosSel             <= decPos;                                  // see R6, R9
      muxNegSel             <= decNeg;                                  // see R7, R10, R11
      bufferBypass          <= decBypass;                               // see R5
      attenuatedPath        <= decHv;                                   // see R14
      referenceSelect       <= curSuReg[ADCMUX_SU_REFSEL_LSB +: 2];     // see R16
      referenceOutputEnable <= modeReg[ADCMUX_MODE_REFEN_BIT];          // see R18, R19
    end
  end

endmodule

//--- dv/adcmux_ctrl_sva.sv
// Checker on the converter control ports: bus answers, mux pairs, reference.
// Assumes a bind onto adcmux_ctrl; one clock, synchronous reset.
`timescale 1ns/1ps
module adcmux_ctrl_sva
  import adcmux_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    srst,
  input wire logic                    awready,
  input wire logic                    wready,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic                    arready,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire logic [31:0]             rdata,
  input wire logic                    convStart,
  input wire logic [ADCMUX_PIN_N-1:0] muxPosSel,
  input wire logic [ADCMUX_PIN_N-1:0] muxNegSel,
  input wire logic                    attenuatedPath,
  input wire logic [1:0]              referenceSelect,
  input wire logic                    referenceOutputEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Pair shape; a shifted pin code shows up as a wrong partner
  property p_onehot;
    $onehot0(muxPosSel) && $onehot0(muxNegSel) && ((muxPosSel == '0) == (muxNegSel == '0));
  endproperty
  property p_hv_pair;
    attenuatedPath && muxPosSel != '0 |-> muxPosSel[16:11] == '0 && (muxNegSel[16] ||
      (muxNegSel == (muxPosSel << 1) && (muxPosSel & 17'h006AA) == '0));
  endproperty
  property p_ll_pair;
    !attenuatedPath && muxPosSel != '0 |-> muxPosSel[10:0] == '0 && !muxPosSel[16] &&
      muxNegSel[10:0] == '0 && !muxNegSel[16] && muxPosSel != muxNegSel;
  endproperty
  property p_ref_reset;
    $past(srst) |-> referenceSelect == ADCMUX_REF_EXT && !referenceOutputEnable;
  endproperty
  property p_refen_cause;
    $changed(referenceOutputEnable) |-> $past(bvalid);
  endproperty
  property p_start_pulse;
    convStart |=> !convStart;
  endproperty
  property p_wr_answer;
    awready |-> wready ##1 bvalid;
  endproperty
  property p_rd_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  property p_rd_answer;
    arready |=> rvalid;
  endproperty

  a_onehot: assert property (p_onehot) else $error("mux select not one-hot");
  a_hv_pair: assert property (p_hv_pair) else $error("bad high-voltage pair");
  a_ll_pair: assert property (p_ll_pair) else $error("bad low-level pair");
  a_ref_reset: assert property (p_ref_reset) else $error("reference not off");
  a_refen_cause: assert property (p_refen_cause) else $error("ref enable moved");
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

  // Main scenarios reached
  c_start: cover property (convStart);
  c_hv: cover property (attenuatedPath && muxPosSel != '0);
  c_reference_output_pin: cover property (referenceOutputEnable);
endmodule

//--- dv/adcmux_conv_model.sv
// Behavioural modulator and filter answering each convStart after a delay.
// Assumes the bench sets delay, raw value and a stall input on clk.
`timescale 1ns/1ps
module adcmux_conv_model
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        convStart,
  input  wire logic        hold,
  input  wire logic [3:0]  delay,
  input  wire logic [23:0] rawIn,
  output logic             convDone,
  output logic [23:0]      convRaw
);
  logic       busy;
  logic [3:0] cnt;

  // Raw bus toggles outside convDone so stale data never looks valid
  always_ff @(posedge clk)
  begin
    convDone <= 1'b0;
    convRaw  <= srst ? 24'h000000 : ~convRaw;
    if (srst)
      busy <= 1'b0;
    else if (convStart)
    begin
      busy <= 1'b1;
      cnt  <= delay;
    end
    else if (busy && !hold && cnt == 4'h0)
    begin
      busy     <= 1'b0;
      convDone <= 1'b1;
      convRaw  <= rawIn;
    end
    else if (busy && !hold)
      cnt <= cnt - 4'h1;
  end
endmodule

//--- dv/adc_input_mux_and_output_coding_tb.sv
// Bench for the converter control block: registers, scan order, coding.
// Assumes the checker and the converter model from this folder.
`timescale 1ns/1ps
bind adcmux_ctrl adcmux_ctrl_sva u_sva (.*);
module adc_input_mux_and_output_coding_tb;
  import adcmux_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, hold = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0, delay = 4'h3;
  logic [23:0] rawIn = 24'h0, convRaw, code;
  logic        awready, wready, bvalid, arready, rvalid, convDone, convStart;
  logic        bufferBypass, attenuatedPath, referenceOutputEnable;
  logic [1:0]  bresp, rresp, referenceSelect;
  logic [16:0] muxPosSel, muxNegSel;
  logic [33:0] rdQ[$], muxQ[$];
  logic        hvQ[$];
  // Divider path expected for slots 2 and 9, not for 5 and 12
  logic        chHv[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int          fail_count = 0, compares = 0, seed = 32'hf164d6bc;
  // Channel slots 2, 5, 9, 12 and their expected pin selects (12 is illegal)
  logic [7:0]  chAddr[4] = '{8'h48, 8'h54, 8'h64, 8'h70};
  logic [15:0] chVal[4] = '{16'h8001, 16'h816F, 16'h8150, 16'h8003};
  logic [33:0] chSel[4] = '{{17'h00001, 17'h00002}, {17'h00800, 17'h08000},
                            {17'h00400, 17'h10000}, 34'h0};
  logic [23:0] raws[4] = '{24'h000000, 24'h7FFFFF, 24'h800000, 24'h000000};
  logic [15:0] setups[2] = '{16'h1030, 16'h0320};

  adcmux_ctrl #(.ADDR_W(8)) u_dut (.*);
  adcmux_conv_model u_model (.*);

  always #5 clk = ~clk;

  // Answer delay changes per conversion: prompt and slow
  always @(posedge clk)
    if (convDone === 1'b1)
      delay <= 4'($random(seed));

  // Read answers against notes in issue order
  always @(posedge clk)
    if (rvalid === 1'b1 && rready === 1'b1 && rdQ.size() > 0)
      check({rresp, rdata}, rdQ.pop_front());

  // Mux selects settle one clock after each start
  always @(posedge clk)
  begin
    #1;
    if (convStart === 1'b1 && muxQ.size() > 0)
    begin
      @(posedge clk);
      #1;
      check({muxPosSel, muxNegSel}, muxQ.pop_front());
      check(34'(attenuatedPath), 34'(hvQ.pop_front()));
    end
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic give_up;
    fail_count++;
    report_and_stop;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] resp);
    int n;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50 && bvalid !== 1'b1; n++)
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == 50) give_up;
    check(34'(bresp), 34'(resp));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
    int n;
    rdQ.push_back(exp);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50 && rvalid !== 1'b1; n++)
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n == 50) give_up;
  endtask

  task automatic wait_done;
    int n;
    @(posedge clk);
    for (n = 0; n < 300 && convDone !== 1'b1; n++)
      @(posedge clk);
    if (n == 300) give_up;
  endtask

  initial
  begin
    raws[3] = 24'($random(seed));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // Reset values, unmapped slot refused
    axi_rd(8'h04, {18'h0, ADCMUX_MODE_RST});
    axi_rd(8'h40, {18'h0, ADCMUX_CH0_RST});
    axi_rd(8'h44, {18'h0, ADCMUX_CHN_RST});
    axi_rd(8'h80, {18'h0, ADCMUX_SETUP_RST});
    axi_rd(8'hFC, {ADCMUX_RESP_SLVERR, 32'h0});
    axi_wr(8'hFC, 16'hFFFF, ADCMUX_RESP_SLVERR);
    check(34'(referenceSelect), 34'(ADCMUX_REF_EXT));
    check(34'(referenceOutputEnable), 34'h0);
    check(34'(bufferBypass), 34'h1);
    $display("reset test done");
    // Channel 0 switched off while its conversion is stalled
    axi_wr(8'h40, 16'h0000, ADCMUX_RESP_OKAY);
    for (int i = 0; i < 4; i++)
      axi_wr(chAddr[i], chVal[i], ADCMUX_RESP_OKAY);
    for (int i = 0; i < 5; i++)
    begin
      muxQ.push_back(chSel[i % 4]);
      hvQ.push_back(chHv[i % 4]);
    end
    hold <= 1'b0;
    for (int n = 0; n < 2000 && muxQ.size() > 0; n++)
      @(posedge clk);
    if (muxQ.size() > 0) give_up;
    $display("scan test done");
    // Bipolar on supply reference, then unipolar buffered on internal reference
    for (int j = 0; j < 2; j++)
    begin
      axi_wr(8'h80, setups[j], ADCMUX_RESP_OKAY);
      for (int k = 0; k < 4; k++)
      begin
        rawIn <= raws[k];
        hold  <= 1'b0;
        wait_done;
        wait_done;
        hold  <= 1'b1;
        code = j == 0 ? {~raws[k][23], raws[k][22:0]} :
               raws[k][23] ? 24'h000000 : {raws[k][22:0], 1'b0};
        axi_rd(8'h10, {10'h0, code});
      end
      check(34'(referenceSelect), j == 0 ? 34'h3 : 34'h2);
      check(34'(bufferBypass), j == 0 ? 34'h1 : 34'h0);
    end
    $display("coding test done");
    // Internal reference drives its pin once enabled
    axi_wr(8'h04, 16'h8000, ADCMUX_RESP_OKAY);
    @(posedge clk);
    #1;
    check(34'(referenceOutputEnable), 34'h1);
    axi_rd(8'h04, {18'h0, 16'h8000});
    @(posedge clk);
    $display("reference test done");
    report_and_stop;
  end
endmodule
